// >>> hdl/pmt_pkg.sv
// constants for the period match timer: register map, field layout, resets
// assumes an 8-bit register port with byte offsets as listed here
package pmt_pkg;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 8;
	localparam logic [7:0]  OFF_FLAGS     = 8'h0c;
	localparam logic [7:0]  OFF_COUNT     = 8'h11;
	localparam logic [7:0]  OFF_CONTROL   = 8'h12;
	localparam logic [7:0]  OFF_ENABLES   = 8'h8c;
	localparam logic [7:0]  OFF_PERIOD    = 8'h92;
	localparam logic [7:0]  RST_FLAGS     = 8'h00;
	localparam logic [7:0]  RST_COUNT     = 8'h00;
	localparam logic [7:0]  RST_CONTROL   = 8'h00;
	localparam logic [7:0]  RST_ENABLES   = 8'h00;
	localparam logic [7:0]  RST_PERIOD    = 8'hff;
	localparam logic [7:0]  CONTROL_MASK  = 8'h7f;
	localparam logic [7:0]  FLAG_MASK     = 8'h02;
	localparam int          FLAG_BIT      = 1;
	localparam int          ON_BIT        = 2;
	localparam int          IDIV_LSB      = 0;
	localparam int          ODIV_LSB      = 3;
	// instruction clock is oscillator/4
	localparam int          ICLK_DIV      = 4;
	localparam logic [1:0]  ICLK_LAST     = 2'h3;
	localparam logic [3:0]  PRE_LAST_1    = 4'h0;
	localparam logic [3:0]  PRE_LAST_4    = 4'h3;
	localparam logic [3:0]  PRE_LAST_16   = 4'hf;
endpackage : pmt_pkg

// >>> hdl/pmt_timer.sv
// period match timer: 8-bit counter, input divider, period match, output divider
// assumes clk is the oscillator, register port strobes are one cycle, synchronous
//
// Overview of operation
// - 8-bit counter, prescaler before, postscaler after
// - prescaler runs off oscillator divided by four
// - input select: 00 /1, 01 /4, 1x /16
// - count up to period, then wrap zero
// - period register read/write, resets to ones
// - 4-bit postscaler sets match flag bit 1
// - output select divides by field plus one
// - control bit 2 turns timer on
// - count/control writes and reset clear dividers
// - control write keeps count value
// - count register read/write, resets zero
// - raw match pulse goes to serial port
// - count and match feed PWM time base
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
module pmt_timer (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      nrst,
	// register port
	input  wire logic [pmt_pkg::ADDR_W-1:0] addr,
	input  wire logic [pmt_pkg::DATA_W-1:0] wdata,
	input  wire logic                      wr_en,
	input  wire logic                      rd_en,
	output logic      [pmt_pkg::DATA_W-1:0] rdata,
	// timer outputs
	output logic                           match_irq,
	output logic                           serial_shift_tick,
	output logic                           pwm_match,
	output logic      [7:0]                pwm_count
);
	import pmt_pkg::*;

	typedef enum logic [1:0] {
		PMT_IDLE = 2'h0,
		PMT_RUN  = 2'h1
	} pmt_state_e;

	logic [7:0]  count_ff;
	logic [7:0]  control_ff;
	logic [7:0]  period_ff;
	logic [7:0]  flags_ff;
	logic [7:0]  enables_ff;
	logic [1:0]  iclk_ff;
	logic [3:0]  pre_ff;
	logic [3:0]  post_ff;
	logic [7:0]  rdata_ff;
	logic        irq_ff;
	logic        tick_ff;
	logic        pwm_match_ff;
	logic [7:0]  pwm_count_ff;
	pmt_state_e  state_ff;

	logic        wr_count;
	logic        wr_control;
	logic        wr_period;
	logic        wr_flags;
	logic        wr_enables;
	logic        running;
	logic        iclk_tick;
	logic        pre_done;
	logic        inc;
	logic        at_period;
	logic        match;
	logic        post_done;
	logic [3:0]  pre_last;
	logic [3:0]  post_last;
	logic [7:0]  nxt_rdata;

	assign wr_count   = wr_en && (addr == OFF_COUNT);
	assign wr_control = wr_en && (addr == OFF_CONTROL);
	assign wr_period  = wr_en && (addr == OFF_PERIOD);
	assign wr_flags   = wr_en && (addr == OFF_FLAGS);
	assign wr_enables = wr_en && (addr == OFF_ENABLES);

	assign running   = control_ff[ON_BIT];
	assign iclk_tick = running && (iclk_ff == ICLK_LAST);

	always_comb begin
		case (control_ff[IDIV_LSB+1:IDIV_LSB])
			2'b00:   pre_last = PRE_LAST_1;
			2'b01:   pre_last = PRE_LAST_4;
			default: pre_last = PRE_LAST_16;
		endcase
	end

	assign pre_done  = iclk_tick && (pre_ff == pre_last);
	// no increment on the cycle software writes the count or control
	assign inc       = pre_done && !wr_count && !wr_control;
	assign at_period = (count_ff == period_ff);
	assign match     = inc && at_period;
	assign post_last = control_ff[ODIV_LSB+3:ODIV_LSB];
	assign post_done = match && (post_ff == post_last);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_ff <= PMT_IDLE;
		end else begin
			case (state_ff)
				PMT_IDLE: state_ff <= running ? PMT_RUN : PMT_IDLE;
				PMT_RUN:  state_ff <= running ? PMT_RUN : PMT_IDLE;
				default:  state_ff <= PMT_IDLE;
			endcase
		end
	end

	// instruction clock phase; frozen while off to hold everything
	always_ff @(posedge clk) begin
		if (!nrst) begin
			iclk_ff <= 2'h0;
		end else if (running) begin
			iclk_ff <= iclk_ff + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || wr_count || wr_control) begin
			pre_ff <= 4'h0;
		end else if (iclk_tick) begin
			pre_ff <= pre_done ? 4'h0 : pre_ff + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || wr_count || wr_control) begin
			post_ff <= 4'h0;
		end else if (match) begin
			post_ff <= post_done ? 4'h0 : post_ff + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			count_ff <= RST_COUNT;
		end else if (wr_count) begin
			count_ff <= wdata;
		end else if (inc) begin
			count_ff <= at_period ? 8'h00 : count_ff + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			control_ff <= RST_CONTROL;
		end else if (wr_control) begin
			control_ff <= wdata & CONTROL_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			period_ff <= RST_PERIOD;
		end else if (wr_period) begin
			period_ff <= wdata;
		end
	end

	// set beats a simultaneous software clear
	always_ff @(posedge clk) begin
		if (!nrst) begin
			flags_ff <= RST_FLAGS;
		end else if (post_done) begin
			flags_ff[FLAG_BIT] <= 1'b1;
		end else if (wr_flags) begin
			flags_ff[FLAG_BIT] <= wdata[FLAG_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			enables_ff <= RST_ENABLES;
		end else if (wr_enables) begin
			enables_ff <= wdata & FLAG_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(flags_ff & enables_ff & FLAG_MASK);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			tick_ff      <= 1'b0;
			pwm_match_ff <= 1'b0;
			pwm_count_ff <= 8'h00;
		end else begin
			tick_ff      <= match;
			pwm_match_ff <= match;
			pwm_count_ff <= count_ff;
		end
	end

	always_comb begin
		nxt_rdata = 8'h00;
		if (rd_en) begin
			case (addr)
				OFF_FLAGS:   nxt_rdata = flags_ff & FLAG_MASK;
				OFF_COUNT:   nxt_rdata = count_ff;
				OFF_CONTROL: nxt_rdata = control_ff;
				OFF_ENABLES: nxt_rdata = enables_ff;
				OFF_PERIOD:  nxt_rdata = period_ff;
				default:     nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata             = rdata_ff;
	assign match_irq         = irq_ff;
	assign serial_shift_tick = tick_ff;
	assign pwm_match         = pwm_match_ff;
	assign pwm_count         = pwm_count_ff;

	// assertions
	sequence s_match_seen;
		match;
	endsequence

	chk_count_wrap: assert property (@(posedge clk) disable iff (!nrst)
		s_match_seen |=> (count_ff == 8'h00))
		else $error("count did not wrap after match");
	chk_count_bound: assert property (@(posedge clk) disable iff (!nrst)
		(inc && !at_period) |=> (count_ff == $past(count_ff) + 8'h01))
		else $error("count did not step by one");
	chk_off_hold: assert property (@(posedge clk) disable iff (!nrst)
		(!running && !wr_count) |=> $stable(count_ff))
		else $error("count moved while off");
	chk_off_nomatch: assert property (@(posedge clk) disable iff (!nrst)
		!running |-> !match)
		else $error("match while off");
	chk_ctl_keep: assert property (@(posedge clk) disable iff (!nrst)
		wr_control |=> (count_ff == $past(count_ff)))
		else $error("control write changed count");
	chk_div_clear: assert property (@(posedge clk) disable iff (!nrst)
		(wr_count || wr_control) |=> (pre_ff == 4'h0 && post_ff == 4'h0))
		else $error("dividers not cleared by write");
	chk_pre_one: assert property (@(posedge clk) disable iff (!nrst)
		(control_ff[1:0] == 2'b00 && iclk_tick) |-> pre_done)
		else $error("divide by one missed tick");
	chk_iclk_rate: assert property (@(posedge clk) disable iff (!nrst)
		iclk_tick |=> !iclk_tick [*3])
		else $error("instruction clock faster than osc/4");
	chk_flag_set: assert property (@(posedge clk) disable iff (!nrst)
		post_done |=> flags_ff[FLAG_BIT])
		else $error("match flag not set");
	chk_post_one: assert property (@(posedge clk) disable iff (!nrst)
		(post_last == 4'h0 && match) |-> post_done)
		else $error("postscale one missed match");
	chk_irq_level: assert property (@(posedge clk) disable iff (!nrst)
		(flags_ff[FLAG_BIT] && enables_ff[FLAG_BIT]) |=> match_irq)
		else $error("irq not raised");
	chk_tick_out: assert property (@(posedge clk) disable iff (!nrst)
		match |=> (serial_shift_tick && pwm_match))
		else $error("match pulse not forwarded");
	chk_period_rst: assert property (@(posedge clk)
		!nrst |=> (period_ff == 8'hff && count_ff == 8'h00))
		else $error("reset values wrong");

	// helper views used only by the checks below
	logic       flag_set_src;
	logic [7:0] flag_bits;

	assign flag_set_src = post_done || (wr_flags && wdata[FLAG_BIT]);
	assign flag_bits    = flags_ff & enables_ff & FLAG_MASK;

	sequence s_count_write;
		wr_count;
	endsequence

	sequence s_ctl_write;
		wr_control;
	endsequence

	// a postscaler event with the enable already standing
	sequence s_flag_armed;
		post_done && enables_ff[FLAG_BIT] && !wr_enables;
	endsequence

	// flag first, interrupt line one cycle later
	sequence s_irq_follows;
		flags_ff[FLAG_BIT] ##1 match_irq;
	endsequence

	sequence s_read_count;
		rd_en && (addr == OFF_COUNT);
	endsequence

	sequence s_read_period;
		rd_en && (addr == OFF_PERIOD);
	endsequence

	sequence s_read_flags;
		rd_en && (addr == OFF_FLAGS);
	endsequence

	// one-edge resets in mid-run are skipped by the past-reset guards
	chk_state_track: assert property (@(posedge clk) disable iff (!nrst)
		$past(nrst) |-> ((state_ff == PMT_RUN) == $past(running)))
		else $error("run state does not follow enable");
	chk_iclk_hold: assert property (@(posedge clk) disable iff (!nrst)
		!running |=> $stable(iclk_ff))
		else $error("instruction phase moved while off");
	chk_pre_hold: assert property (@(posedge clk) disable iff (!nrst)
		(!running && !wr_count && !wr_control) |=> $stable(pre_ff))
		else $error("prescaler moved while off");
	chk_post_hold: assert property (@(posedge clk) disable iff (!nrst)
		(!running && !wr_count && !wr_control) |=> $stable(post_ff))
		else $error("postscaler moved while off");
	chk_pre_wrap: assert property (@(posedge clk) disable iff (!nrst)
		(pre_done && !wr_count && !wr_control) |=> (pre_ff == 4'h0))
		else $error("prescaler did not restart");
	chk_post_step: assert property (@(posedge clk) disable iff (!nrst)
		(match && !post_done) |=> (post_ff == $past(post_ff) + 4'h1))
		else $error("postscaler did not step");
	chk_post_wrap: assert property (@(posedge clk) disable iff (!nrst)
		post_done |=> (post_ff == 4'h0))
		else $error("postscaler did not restart");
	chk_match_gap: assert property (@(posedge clk) disable iff (!nrst)
		match |=> !match [*3])
		else $error("matches closer than one instruction cycle");
	chk_wrap_bound: assert property (@(posedge clk) disable iff (!nrst)
		(count_ff <= period_ff && !wr_count && !wr_period) |=> (count_ff <= period_ff))
		else $error("count ran past period");

	// register loads and read-back
	chk_count_load: assert property (@(posedge clk) disable iff (!nrst)
		s_count_write |=> (count_ff == $past(wdata)))
		else $error("count write lost");
	chk_period_load: assert property (@(posedge clk) disable iff (!nrst)
		wr_period |=> (period_ff == $past(wdata)))
		else $error("period write lost");
	chk_ctl_load: assert property (@(posedge clk) disable iff (!nrst)
		s_ctl_write |=> (control_ff == ($past(wdata) & CONTROL_MASK)))
		else $error("control write lost");
	chk_rd_count: assert property (@(posedge clk) disable iff (!nrst)
		s_read_count |=> (rdata == $past(count_ff)))
		else $error("count read wrong");
	chk_rd_period: assert property (@(posedge clk) disable iff (!nrst)
		s_read_period |=> (rdata == $past(period_ff)))
		else $error("period read wrong");
	chk_rd_flags: assert property (@(posedge clk) disable iff (!nrst)
		s_read_flags |=> (rdata == ($past(flags_ff) & FLAG_MASK)))
		else $error("flag read wrong");

	// flag, interrupt and forwarded pulses
	chk_flag_keep: assert property (@(posedge clk) disable iff (!nrst)
		(flags_ff[FLAG_BIT] && !wr_flags) |=> flags_ff[FLAG_BIT])
		else $error("match flag dropped by itself");
	chk_flag_clear: assert property (@(posedge clk) disable iff (!nrst)
		(wr_flags && !wdata[FLAG_BIT] && !post_done) |=> !flags_ff[FLAG_BIT])
		else $error("match flag not cleared");
	chk_flag_cause: assert property (@(posedge clk) disable iff (!nrst)
		$rose(flags_ff[FLAG_BIT]) |-> $past(flag_set_src))
		else $error("match flag set without cause");
	chk_irq_path: assert property (@(posedge clk) disable iff (!nrst)
		s_flag_armed |=> s_irq_follows)
		else $error("postscaler event did not reach irq");
	chk_irq_low: assert property (@(posedge clk) disable iff (!nrst)
		(flag_bits == 8'h00) |=> !match_irq)
		else $error("irq without unmasked flag");
	chk_tick_pulse: assert property (@(posedge clk) disable iff (!nrst)
		serial_shift_tick |=> !serial_shift_tick)
		else $error("serial tick longer than one cycle");
	chk_tick_cause: assert property (@(posedge clk) disable iff (!nrst)
		serial_shift_tick |-> $past(match))
		else $error("serial tick without match");
	chk_pwm_base: assert property (@(posedge clk) disable iff (!nrst)
		$past(nrst) |-> (pwm_count == $past(count_ff)))
		else $error("pwm count does not follow count");
	chk_rst_div: assert property (@(posedge clk)
		!nrst |=> (pre_ff == 4'h0 && post_ff == 4'h0 && control_ff == 8'h00))
		else $error("dividers not cleared by reset");
	chk_rst_outs: assert property (@(posedge clk)
		!nrst |=> (match_irq == 1'b0 && flags_ff == 8'h00 && enables_ff == 8'h00))
		else $error("flags or irq not cleared by reset");
endmodule : pmt_timer

// >>> verif/tb_period_match_timer8.sv
// self-checking bench for the period match timer: registers, dividers, wrap, irq
// assumes a 25 MHz clk, synchronous active-low nrst, reads answered the next cycle
`timescale 1ns/100ps
module tb_period_match_timer8;
	import pmt_pkg::*;
	logic       clk       = 1'b0;
	logic       nrst      = 1'b0;
	logic       wr_en     = 1'b0;
	logic       rd_en     = 1'b0;
	logic [7:0] addr      = 8'h00;
	logic [7:0] wdata     = 8'h00;
	logic [7:0] rdata;
	logic       match_irq;
	logic       serial_shift_tick;
	logic       pwm_match;
	logic [7:0] pwm_count;
	logic [7:0] rnd       = 8'h24;
	int         err_total = 0;
	int         checks    = 0;

	pmt_timer pmt_timer_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .match_irq(match_irq),
		.serial_shift_tick(serial_shift_tick), .pwm_match(pwm_match), .pwm_count(pwm_count));

	always #20 clk = ~clk;

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next

	// clocks between raw matches: instruction clock /4, prescale, period+1 steps
	function automatic logic [15:0] exp_interval(input logic [1:0] c, input logic [7:0] p);
		return 16'(ICLK_DIV * (c == 2'h0 ? 1 : (c == 2'h1 ? 4 : 16)) * (p + 1));
	endfunction : exp_interval

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask : rd

	// cycles until the next raw match pulse, bounded
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (serial_shift_tick !== 1'b1 && n < 3000);
		chk("tick seen", 16'h1, 16'(serial_shift_tick));
		chk("pwm_match", 16'h1, 16'(pwm_match));
	endtask : wait_tick

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end

	initial begin
		logic [7:0] offs [5];
		logic [7:0] rsts [5];
		logic [3:0] odiv [4];
		logic [7:0] d;
		logic [7:0] v;
		logic [7:0] p;
		int         n;
		int         k;
		offs = '{OFF_FLAGS, OFF_COUNT, OFF_CONTROL, OFF_ENABLES, OFF_PERIOD};
		rsts = '{RST_FLAGS, RST_COUNT, RST_CONTROL, RST_ENABLES, RST_PERIOD};
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(offs[i], d);
			chk("reset value", 16'(rsts[i]), 16'(d));
		end
		wr(8'h00, 8'hff);
		rd(8'h00, d);
		chk("unmapped", 16'h0, 16'(d));
		$display("test reset values done");

		rnd = lfsr_next(rnd);
		wr(OFF_CONTROL, rnd | 8'h80);
		rd(OFF_CONTROL, d);
		chk("control", 16'(rnd & CONTROL_MASK), 16'(d));
		rnd = lfsr_next(rnd);
		wr(OFF_PERIOD, rnd);
		rd(OFF_PERIOD, d);
		chk("period", 16'(rnd), 16'(d));
		wr(OFF_CONTROL, 8'h00);
		v = lfsr_next(rnd);
		wr(OFF_COUNT, v);
		rd(OFF_COUNT, d);
		chk("count", 16'(v), 16'(d));
		chk("pwm_count", 16'(v), 16'(pwm_count));
		wr(OFF_CONTROL, 8'h7b);
		n = 0;
		repeat (60) begin
			@(posedge clk);
			#1 if (serial_shift_tick === 1'b1) n++;
		end
		rd(OFF_COUNT, d);
		chk("count held", 16'(v), 16'(d));
		chk("ticks while off", 16'h0, 16'(n));
		$display("test registers and off done");

		// every prescale code, random small period, wrap to zero after match
		for (int c = 0; c < 4; c++) begin
			rnd = lfsr_next(rnd);
			p   = rnd & 8'h07;
			wr(OFF_CONTROL, 8'h00);
			wr(OFF_PERIOD, p);
			wr(OFF_COUNT, 8'h00);
			wr(OFF_CONTROL, 8'h04 | 8'(c));
			wait_tick(n);
			chk("count at match", 16'(p), 16'(pwm_count));
			@(posedge clk);
			#1 chk("count after wrap", 16'h0, 16'(pwm_count));
			wait_tick(n);
			// n starts one cycle after the first pulse
			chk("match interval", exp_interval(2'(c), p), 16'(n) + 16'h1);
		end
		$display("test prescale done");

		rnd     = lfsr_next(rnd);
		odiv    = '{4'h0, 4'h1, 4'hf, rnd[3:0]};
		for (int j = 0; j < 4; j++) begin
			wr(OFF_CONTROL, 8'h00);
			wr(OFF_PERIOD, 8'h00);
			wr(OFF_ENABLES, FLAG_MASK);
			wr(OFF_FLAGS, 8'h00);
			wr(OFF_CONTROL, 8'h04 | {1'b0, odiv[j], 3'h0});
			n = 0;
			k = 0;
			while (match_irq !== 1'b1 && k < 2000) begin
				@(posedge clk);
				#1 k++;
				if (serial_shift_tick === 1'b1) n++;
			end
			chk("matches per flag", 16'(odiv[j]) + 16'h1, 16'(n));
			rd(OFF_FLAGS, d);
			chk("flag set", 16'(FLAG_MASK), 16'(d));
		end
		$display("test postscale done");

		wr(OFF_ENABLES, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk("irq masked", 16'h0, 16'(match_irq));
		wr(OFF_ENABLES, FLAG_MASK);
		repeat (2) @(posedge clk);
		#1 chk("irq unmasked", 16'h1, 16'(match_irq));
		wr(OFF_CONTROL, 8'h00);
		wr(OFF_FLAGS, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk("irq cleared", 16'h0, 16'(match_irq));
		$display("test interrupt done");
		tally_and_finish();
	end
endmodule : tb_period_match_timer8
